// ### rtl/tle_core.v
/*
  thermal limit event logic: capability, configuration, three limit
  registers and the temperature data register with trip status, plus the
  open-drain event pin in comparator, interrupt or critical-only mode.
  assumes a serial bus engine on clk_i that presents word accesses by
  pointer, and a converter on clk_i that answers a start pulse with a
  13-bit result and a one-cycle done strobe.

  // Behaviour
  // - capability upper byte zero, writes ignored
  // - capability bit 7 gives shutdown status behaviour
  // - resolution field sets lsb, masks data
  // - hysteresis field selects 0/1.5/3/6 degC
  // - halt bit stops conversion, freezes data
  // - lock bits block limit writes, POR-clear only
  // - clear bit clears interrupt latch, reads zero
  // - disabled output floats or grounds by polarity
  // - critical-only bit; blocked by alarm lock
  // - polarity bit: 0 active low, 1 high
  // - mode bit: 0 comparator, 1 interrupt
  // - locks freeze hysteresis, enable, polarity, mode
  // - halt cannot be set while locked
  // - status bit mirrors asserted event, clear-only halted
  // - limits two's complement, bits 12..2 kept
  // - data bits 12..0 signed temperature
  // - trip status bits independent of event setup
  // - interrupt mode latches window crossings
  // - clear deferred while above critical limit
  // - comparator follows window; critical-only ignores clear
  // - halt keeps event pin state
  // - limit writes re-evaluate event at once
  // - new conversion at least every 100 ms
  // - writable registers reset to zero
*/
`timescale 1ns/1ps
`include "tle_defines.vh"

module tle_core #(
  parameter CONV_CYCLES = `TLE_CLK_HZ / 1000 * `TLE_CONV_PERIOD_MS, // cycles per conversion
  parameter [15:0] MFG_ID = 16'h0a5a, // arbitrary value, not a real maker code
  parameter [15:0] DEV_ID = 16'h0101 // arbitrary value, not a real part code
) (
  input wire clk_i, // 25 MHz block clock
  input wire nrst_i, // power-on reset, active low
  input wire [2:0] reg_ptr_i, // register pointer
  input wire reg_wr_i, // write strobe, one cycle
  input wire [15:0] reg_wdata_i, // write word
  input wire reg_rd_i, // read strobe, one cycle
  output reg [15:0] reg_rdata_o, // read word, valid cycle after strobe
  output reg reg_rvalid_o, // read word valid pulse
  output reg conv_start_o, // converter start pulse
  input wire conv_done_i, // converter result strobe
  input wire [12:0] conv_data_i, // converter result, 0.0625 degC lsb
  output reg event_out_o, // event pin output level, always low
  output reg event_oe_o // event pin pull-down enable
);

  // 22 bits covers 2.5 million cycles
  localparam CNT_W = 22;
  // last count kept at integer width; the counter is widened to meet it
  localparam integer CONV_LAST = CONV_CYCLES - 1;

  // sign-extend a 13-bit temperature to 14 bits for safe offsets
  function [13:0] tle_sx;
    input [12:0] v;
    begin
      tle_sx = {v[12], v};
    end
  endfunction

  // signed a < b on 14-bit values
  function tle_lt;
    input [13:0] a;
    input [13:0] b;
    begin
      tle_lt = $signed(a) < $signed(b);
    end
  endfunction

  // hysteresis step from the two-bit field
  function [13:0] tle_hys_step;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: tle_hys_step = `TLE_HYS_1P5;
        2'h2: tle_hys_step = `TLE_HYS_3;
        2'h3: tle_hys_step = `TLE_HYS_6;
        default: tle_hys_step = 14'h0000;
      endcase
    end
  endfunction

  // configuration and limit storage
  reg [1:0] hysteresis_select_reg; // hysteresis step select
  reg sensor_halt_reg; // conversions stopped
  reg critical_limit_freeze_reg; // critical limit locked
  reg alarm_freeze_reg; // alarm limits locked
  reg alert_asserted_flag_reg; // polarity-free event copy
  reg alert_enable_reg; // event pin enabled
  reg critical_only_select_reg; // only critical raises events
  reg alert_polarity_reg; // 1 = active high
  reg alert_mode_reg; // 1 = interrupt mode
  reg [12:0] upper_alarm_limit_reg; // bits 12..0 of high limit
  reg [12:0] lower_alarm_limit_reg; // bits 12..0 of low limit
  reg [12:0] critical_limit_reg; // bits 12..0 of critical limit
  reg [12:0] temp_reg; // last converted temperature
  // trip conditions with hysteresis
  reg above_critical_flag_reg; // at or above critical
  reg above_high_reg; // above high limit
  reg below_low_reg; // below low limit
  reg window_prev_reg; // last sampled window state
  // interrupt machinery
  reg int_latch_reg; // latched window crossing
  reg clear_pend_reg; // clear held off by critical
  // conversion timer
  reg [CNT_W-1:0] conv_cnt_reg; // cycles since last start

  wire any_lock = critical_limit_freeze_reg | alarm_freeze_reg;
  wire cfg_wr = reg_wr_i && (reg_ptr_i == `TLE_PTR_CFG);
  // clear pulse from write of one
  wire clear_req = cfg_wr && reg_wdata_i[`TLE_CFG_CLEAR];
  wire [13:0] hys_step = tle_hys_step(hysteresis_select_reg);
  wire [13:0] t_x = tle_sx(temp_reg);
  wire [13:0] hi_x = tle_sx(upper_alarm_limit_reg);
  wire [13:0] lo_x = tle_sx(lower_alarm_limit_reg);
  wire [13:0] cr_x = tle_sx(critical_limit_reg);

  // set at the critical limit and past the high and low limits, release once hysteresis back inside the limit (low limit plus, others minus)
  // limits feed these compares directly, no sample wait
  wire crit_next = above_critical_flag_reg ? !tle_lt(t_x, cr_x - hys_step) : !tle_lt(t_x, cr_x);
  wire high_next = above_high_reg ? tle_lt(hi_x - hys_step, t_x) : tle_lt(hi_x, t_x);
  wire low_next = below_low_reg ? tle_lt(t_x, lo_x + hys_step) : tle_lt(t_x, lo_x);
  wire window_now = above_high_reg | below_low_reg;

  // trip compares, still running while halted; only the data is frozen
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      above_critical_flag_reg <= 1'b0;
      above_high_reg <= 1'b0;
      below_low_reg <= 1'b0;
      window_prev_reg <= 1'b0;
    end else begin
      // status from compares only, no event settings
      above_critical_flag_reg <= crit_next;
      above_high_reg <= high_next;
      below_low_reg <= low_next;
      window_prev_reg <= window_now;
    end
  end

  // interrupt latch: set wins over clear in the same cycle
  wire win_cross = (window_now != window_prev_reg) && !critical_only_select_reg;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_latch_reg <= 1'b0;
      clear_pend_reg <= 1'b0;
    end else if (!alert_mode_reg || critical_only_select_reg) begin
      // no latching, clears ignored in these modes
      int_latch_reg <= 1'b0;
      clear_pend_reg <= 1'b0;
    end else if (!sensor_halt_reg && win_cross) begin
      // each window crossing while not halted latches an event
      int_latch_reg <= 1'b1;
      clear_pend_reg <= 1'b0;
    end else if (above_critical_flag_reg) begin
      // clear accepted, held until below critical
      if (clear_req)
        clear_pend_reg <= 1'b1;
    end else if (clear_req || clear_pend_reg) begin
      // clear latched event in interrupt mode
      int_latch_reg <= 1'b0;
      clear_pend_reg <= 1'b0;
    end
  end

  // asserted event state before the enable and polarity stages
  reg asserted_now;
  always @* begin
    if (critical_only_select_reg)
      asserted_now = above_critical_flag_reg; // critical only
    else if (alert_mode_reg)
      asserted_now = int_latch_reg | above_critical_flag_reg;
    else
      asserted_now = window_now | above_critical_flag_reg;
  end

  // configuration word writes and the status copy
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // all writable bits start at zero
      hysteresis_select_reg <= 2'h0;
      sensor_halt_reg <= 1'b0;
      critical_limit_freeze_reg <= 1'b0;
      alarm_freeze_reg <= 1'b0;
      alert_enable_reg <= 1'b0;
      critical_only_select_reg <= 1'b0;
      alert_polarity_reg <= 1'b0;
      alert_mode_reg <= 1'b0;
      alert_asserted_flag_reg <= 1'b0;
    end else begin
      if (cfg_wr) begin
        // locks only set by writes; reset alone clears them
        critical_limit_freeze_reg <= critical_limit_freeze_reg |
          reg_wdata_i[`TLE_CFG_CRIT_LOCK];
        alarm_freeze_reg <= alarm_freeze_reg | reg_wdata_i[`TLE_CFG_ALARM_LOCK];
        sensor_halt_reg <= reg_wdata_i[`TLE_CFG_HALT] & (sensor_halt_reg | !any_lock);
        // critical-only not settable under alarm lock
        critical_only_select_reg <= reg_wdata_i[`TLE_CFG_CRIT_ONLY] &
          (critical_only_select_reg | !alarm_freeze_reg);
        if (!any_lock) begin
          hysteresis_select_reg <= reg_wdata_i[`TLE_CFG_HYS_HI:`TLE_CFG_HYS_LO];
          alert_enable_reg <= reg_wdata_i[`TLE_CFG_EN];
          alert_polarity_reg <= reg_wdata_i[`TLE_CFG_POL];
          alert_mode_reg <= reg_wdata_i[`TLE_CFG_MODE];
        end
      end
      if (sensor_halt_reg) begin
        // while halted the copy may be cleared, never set
        // otherwise the pre-halt state is held
        if (clear_req)
          alert_asserted_flag_reg <= 1'b0;
      end else if (cfg_wr && reg_wdata_i[`TLE_CFG_HALT] && !any_lock &&
                   (`TLE_CAP_SD_BEHAV == 1'b1)) begin
        // capability says halting releases the event
        alert_asserted_flag_reg <= 1'b0;
      end else begin
        // copy of the asserted pin, gated by the enable
        alert_asserted_flag_reg <= asserted_now & alert_enable_reg;
      end
    end
  end

  // limit register writes
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      upper_alarm_limit_reg <= 13'h0000;
      lower_alarm_limit_reg <= 13'h0000;
      critical_limit_reg <= 13'h0000;
    end else if (reg_wr_i) begin
      if (reg_ptr_i == `TLE_PTR_HIGH && !alarm_freeze_reg)
        upper_alarm_limit_reg <= reg_wdata_i[12:0] & `TLE_LIMIT_MASK;
      if (reg_ptr_i == `TLE_PTR_LOW && !alarm_freeze_reg)
        lower_alarm_limit_reg <= reg_wdata_i[12:0] & `TLE_LIMIT_MASK;
      if (reg_ptr_i == `TLE_PTR_CRIT && !critical_limit_freeze_reg)
        critical_limit_reg <= reg_wdata_i[12:0] & `TLE_LIMIT_MASK;
    end
  end

  // conversion timer and data capture; reads never touch it
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_cnt_reg <= {CNT_W{1'b0}};
      conv_start_o <= 1'b0;
      temp_reg <= 13'h0000;
    end else begin
      // one start per period while running
      conv_start_o <= !sensor_halt_reg && (conv_cnt_reg == {CNT_W{1'b0}});
      if (sensor_halt_reg || {{(32-CNT_W){1'b0}}, conv_cnt_reg} == CONV_LAST)
        conv_cnt_reg <= {CNT_W{1'b0}};
      else
        conv_cnt_reg <= conv_cnt_reg + 1'b1;
      // signed 13-bit result kept as delivered
      if (conv_done_i && !sensor_halt_reg)
        temp_reg <= conv_data_i;
    end
  end

  // blank data bits below the stated resolution
  function [12:0] tle_res_mask;
    input [1:0] res;
    begin
      case (res)
        2'h0: tle_res_mask = 13'h1ff8;
        2'h1: tle_res_mask = 13'h1ffc;
        2'h2: tle_res_mask = 13'h1ffe;
        default: tle_res_mask = 13'h1fff;
      endcase
    end
  endfunction

  // read mux
  reg [15:0] rd_word;
  always @* begin
    case (reg_ptr_i)
      `TLE_PTR_CAP: rd_word = {8'h00, `TLE_CAP_SD_BEHAV, `TLE_CAP_TIMEOUT,
        `TLE_CAP_OVERDRIVE, `TLE_CAP_RES, `TLE_CAP_RANGE, `TLE_CAP_ACCURACY, `TLE_CAP_EVENT};
      `TLE_PTR_CFG: rd_word = {5'h00, hysteresis_select_reg, sensor_halt_reg,
        critical_limit_freeze_reg, alarm_freeze_reg, 1'b0, alert_asserted_flag_reg,
        alert_enable_reg, critical_only_select_reg, alert_polarity_reg, alert_mode_reg};
      `TLE_PTR_HIGH: rd_word = {3'h0, upper_alarm_limit_reg};
      `TLE_PTR_LOW: rd_word = {3'h0, lower_alarm_limit_reg};
      `TLE_PTR_CRIT: rd_word = {3'h0, critical_limit_reg};
      // trip status on top of the temperature
      `TLE_PTR_TEMP: rd_word = {above_critical_flag_reg, above_high_reg, below_low_reg,
        temp_reg & tle_res_mask(`TLE_CAP_RES)};
      `TLE_PTR_MFG: rd_word = MFG_ID;
      `TLE_PTR_DEV: rd_word = DEV_ID;
      default: rd_word = `TLE_ZERO16;
    endcase
  end

  // registered read answer, one cycle after the strobe
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= `TLE_ZERO16;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_word;
    end
  end

  // event pin: open drain, so only the pull-down is ever driven
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      event_out_o <= 1'b0;
      event_oe_o <= 1'b0;
    end else begin
      event_out_o <= 1'b0;
      if (!alert_enable_reg)
        // disabled floats for low, grounds for high
        event_oe_o <= alert_polarity_reg;
      else
        // low polarity pulls when asserted, high when idle
        event_oe_o <= alert_polarity_reg ^ alert_asserted_flag_reg;
    end
  end

endmodule

// ### inc/tle_defines.vh
/*
  constants of the thermal limit event logic: register pointers, bit
  positions, reset values, hysteresis steps and conversion timing.
  assumes inclusion by bare name from the design file only.
*/
`ifndef TLE_DEFINES_VH
`define TLE_DEFINES_VH
// register pointer values
`define TLE_PTR_CAP 3'h0
`define TLE_PTR_CFG 3'h1
`define TLE_PTR_HIGH 3'h2
`define TLE_PTR_LOW 3'h3
`define TLE_PTR_CRIT 3'h4
`define TLE_PTR_TEMP 3'h5
`define TLE_PTR_MFG 3'h6
`define TLE_PTR_DEV 3'h7
// configuration word bit positions
`define TLE_CFG_HYS_HI 10
`define TLE_CFG_HYS_LO 9
`define TLE_CFG_HALT 8
`define TLE_CFG_CRIT_LOCK 7
`define TLE_CFG_ALARM_LOCK 6
`define TLE_CFG_CLEAR 5
`define TLE_CFG_STS 4
`define TLE_CFG_EN 3
`define TLE_CFG_CRIT_ONLY 2
`define TLE_CFG_POL 1
`define TLE_CFG_MODE 0
// temperature data status bit positions
`define TLE_TD_CRIT 15
`define TLE_TD_HIGH 14
`define TLE_TD_LOW 13
// capability fields
`define TLE_CAP_SD_BEHAV 1'b0
`define TLE_CAP_TIMEOUT 1'b1
`define TLE_CAP_OVERDRIVE 1'b1
`define TLE_CAP_RES 2'h3
`define TLE_CAP_RANGE 1'b1
`define TLE_CAP_ACCURACY 1'b1
`define TLE_CAP_EVENT 1'b1
// hysteresis in 0.0625 degC steps: 1.5, 3 and 6 degC
`define TLE_HYS_1P5 14'h0018
`define TLE_HYS_3 14'h0030
`define TLE_HYS_6 14'h0060
// limit registers keep bits 12..2 only, sized to the 13-bit storage
`define TLE_LIMIT_MASK 13'h1ffc
`define TLE_ZERO16 16'h0000
// conversion period
`define TLE_CONV_PERIOD_MS 100
`define TLE_CLK_HZ 25000000
`endif

// ### sim/tle_core_monitor.sv
/*
  checker of the thermal limit event logic: register answers and pins.
  assumes a bind onto the core; it sees only the core's ports.
*/
`timescale 1ns/1ps
module tle_core_monitor (
  input wire clk_i, // block clock
  input wire nrst_i, // reset, active low
  input wire [2:0] reg_ptr_i, // pointer
  input wire reg_wr_i, // write strobe
  input wire [15:0] reg_wdata_i, // write word
  input wire reg_rd_i, // read strobe
  input wire [15:0] reg_rdata_o, // read word
  input wire reg_rvalid_o, // read valid
  input wire conv_start_o, // start pulse
  input wire conv_done_i, // result strobe
  input wire [12:0] conv_data_i, // result
  input wire event_out_o, // pin drive level
  input wire event_oe_o // pin pull-down
);
  // one clock domain, so defaults once
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // read requests by register kind
  sequence rd_req; reg_rd_i; endsequence
  sequence cap_rd; reg_rd_i && reg_ptr_i == 3'h0; endsequence
  sequence cfg_rd; reg_rd_i && reg_ptr_i == 3'h1; endsequence
  sequence lim_rd; reg_rd_i && reg_ptr_i >= 3'h2 && reg_ptr_i <= 3'h4; endsequence
  cap_upper_a: assert property (cap_rd |=> reg_rdata_o[15:8] == 8'h00)
    else $error("capability upper byte not zero");
  cap_halt_a: assert property (cap_rd |=> reg_rdata_o[7] == 1'b0)
    else $error("capability halt behaviour bit wrong");
  cap_res_a: assert property (cap_rd |=> reg_rdata_o[4:3] == 2'h3)
    else $error("capability resolution field wrong");
  clear_reads_a: assert property (cfg_rd |=> reg_rdata_o[15:11] == 5'h00 && !reg_rdata_o[5])
    else $error("configuration reserved or clear bit set");
  status_en_a: assert property (cfg_rd |=> !(reg_rdata_o[4] && !reg_rdata_o[3]))
    else $error("status set with output disabled");
  limit_pad_a: assert property (lim_rd |=> reg_rdata_o[15:13] == 3'h0 &&
    reg_rdata_o[1:0] == 2'h0)
    else $error("limit padding bits not zero");
  // answer one cycle after each read, held otherwise
  read_answer_a: assert property (rd_req |=> reg_rvalid_o)
    else $error("read not answered next cycle");
  read_hold_a: assert property (!reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o))
    else $error("read word changed without a read");
  drain_only_a: assert property (event_oe_o |-> !event_out_o)
    else $error("event pin driven high");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
endmodule

bind tle_core tle_core_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
  .reg_ptr_i(reg_ptr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
  .conv_data_i(conv_data_i), .event_out_o(event_out_o), .event_oe_o(event_oe_o));

// ### sim/tle_conv_model.sv
/*
  behavioural converter: answers each start with a result after a delay.
  assumes the core's clock; the temperature comes from the bench.
*/
`timescale 1ns/1ps
module tle_conv_model #(
  parameter DLY = 3 // cycles from start to result
) (
  input wire clk_i, // block clock
  input wire nrst_i, // reset, active low
  input wire start_i, // start pulse from core
  input wire [12:0] temp_i, // temperature to report
  output reg done_o, // result strobe
  output reg [12:0] data_o // result, garbled off the strobe
);
  integer cnt; // cycles left, zero when idle
  // count down, strobe on the last step
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      data_o <= 13'h0000;
    end else begin
      done_o <= (cnt == 1);
      // off the strobe the data toggles so stale values never look valid
      data_o <= (cnt == 1) ? temp_i : ~data_o;
      if (start_i) begin
        cnt <= DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ### sim/tb.sv
/*
  testbench of the thermal limit event logic, self-checking.
  assumes the converter model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0; // 25 MHz clock
  logic nrst_i = 1'b0; // power-on reset
  logic [2:0] reg_ptr_i = 3'h0; // pointer
  logic reg_wr_i = 1'b0; // write strobe
  logic reg_rd_i = 1'b0; // read strobe
  logic [15:0] reg_wdata_i = 16'h0000; // write word
  logic [15:0] reg_rdata_o; // read word
  logic reg_rvalid_o; // read valid
  logic conv_start_o; // start pulse
  logic conv_done_i; // result strobe
  logic [12:0] conv_data_i; // result
  logic event_out_o; // pin drive level
  logic event_oe_o; // pin pull-down
  logic [12:0] temp = 13'h0100; // modelled die temperature
  wire pin = event_oe_o ? event_out_o : 1'b1; // pin with pull-up
  int fails = 0; // mismatches
  int compares = 0; // comparisons made
  int cyc = 0; // cycles run
  // free running clock
  always #20 clk_i = ~clk_i;
  // short conversion period keeps the run small
  tle_core #(.CONV_CYCLES(50)) DUT (.clk_i(clk_i), .nrst_i(nrst_i),
    .reg_ptr_i(reg_ptr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .event_out_o(event_out_o), .event_oe_o(event_oe_o));
  tle_conv_model u_conv (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(conv_start_o),
    .temp_i(temp), .done_o(conv_done_i), .data_o(conv_data_i));
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [2:0] p, input logic [15:0] d);
    @(posedge clk_i);
    #1 reg_wr_i = 1'b1;
    reg_ptr_i = p;
    reg_wdata_i = d;
    @(posedge clk_i);
    #1 reg_wr_i = 1'b0;
  endtask
  // read strobe, word is there one cycle later
  task rd(input logic [2:0] p, input logic [15:0] e);
    @(posedge clk_i);
    #1 reg_rd_i = 1'b1;
    reg_ptr_i = p;
    @(posedge clk_i);
    #1 reg_rd_i = 1'b0;
    chk($sformatf("reg%0d", p), reg_rdata_o, e);
  endtask
  // pin level once the event pipeline has settled
  task ev(input logic e);
    repeat (5) @(posedge clk_i);
    #1 chk("pin", {15'h0000, pin}, {15'h0000, e});
  endtask
  // two full conversions at the new temperature
  task run(input logic [12:0] t);
    temp = t;
    repeat (130) @(posedge clk_i);
  endtask
  task tally_and_finish;
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, well above the expected few thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    rd(3'h0, 16'h007f);
    for (int p = 1; p < 5; p++) rd(p[2:0], 16'h0000);
    ev(1'b1);
    wr(3'h0, 16'hffff);
    rd(3'h0, 16'h007f);
    wr(3'h2, 16'hffff);
    rd(3'h2, 16'h1ffc);
    wr(3'h2, 16'h0190);
    wr(3'h3, 16'h0050);
    wr(3'h4, 16'h0320);
    run(13'h0100);
    rd(3'h5, 16'h0100);
    wr(3'h1, 16'h0008);
    ev(1'b1);
    run(13'h0200);
    rd(3'h5, 16'h4200);
    ev(1'b0);
    rd(3'h1, 16'h0018);
    wr(3'h1, 16'h0208);
    run(13'h0180);
    rd(3'h5, 16'h4180);
    run(13'h0178);
    rd(3'h5, 16'h0178);
    wr(3'h2, 16'h00c0);
    rd(3'h5, 16'h4178);
    wr(3'h2, 16'h0190);
    wr(3'h1, 16'h0029);
    ev(1'b1);
    run(13'h0200);
    ev(1'b0);
    wr(3'h1, 16'h0029);
    ev(1'b1);
    rd(3'h1, 16'h0009);
    run(13'h0400);
    wr(3'h1, 16'h0029);
    ev(1'b0);
    run(13'h0100);
    wr(3'h1, 16'h0002);
    ev(1'b0);
    wr(3'h1, 16'h000a);
    run(13'h0200);
    ev(1'b1);
    wr(3'h1, 16'h000c);
    ev(1'b1);
    run(13'h0400);
    ev(1'b0);
    wr(3'h1, 16'h0008);
    wr(3'h1, 16'h0108);
    run(13'h0100);
    rd(3'h5, 16'hc400);
    ev(1'b0);
    wr(3'h1, 16'h0128);
    ev(1'b1);
    rd(3'h1, 16'h0108);
    wr(3'h1, 16'h0008);
    run(13'h0100);
    rd(3'h5, 16'h0100);
    wr(3'h1, 16'h0608);
    run(13'h0040);
    rd(3'h5, 16'h2040);
    ev(1'b0);
    run(13'h0090);
    rd(3'h5, 16'h2090);
    run(13'h0100);
    rd(3'h5, 16'h0100);
    wr(3'h1, 16'h0048);
    wr(3'h2, 16'h0aa8);
    rd(3'h2, 16'h0190);
    wr(3'h4, 16'h0600);
    rd(3'h4, 16'h0600);
    wr(3'h1, 16'h07cf);
    rd(3'h1, 16'h00c8);
    wr(3'h1, 16'h0000);
    rd(3'h1, 16'h00c8);
    wr(3'h4, 16'h0004);
    rd(3'h4, 16'h0600);
    // second power-on: only this may drop the lock bits
    @(posedge clk_i);
    #1 nrst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    rd(3'h1, 16'h0000);
    rd(3'h4, 16'h0000);
    ev(1'b1);
    tally_and_finish;
  end
endmodule
